// ---- src/pin_mux_params.svh ----
// Offsets, field positions, reset values and timing counts of the pin mux
`ifndef PIN_MUX_PARAMS_SVH
`define PIN_MUX_PARAMS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_SYS_OPTIONS 5'h00
`define OFS_PORT_DATA 5'h04
`define OFS_PORT_DIR 5'h08
`define OFS_PULL_EN 5'h0C
`define OFS_PULL_UP_SEL 5'h10
`define OFS_KEY_WAKE_EN 5'h14
`define OFS_PERIPH_CTRL 5'h18
`define OFS_PIN_STATUS 5'h1C

// ****************************************
// Field positions
// ****************************************
`define BIT_RESET_PIN_ENABLE 0
`define BIT_DEBUG_PIN_ENABLE 1
`define BIT_CMP_IN_EN 0
`define BIT_CMP_OUT_EN 1
`define BIT_TIMER_EXT_CLOCK_IN_EN 2
`define BIT_STAT_BG_MODE 8
`define BIT_STAT_RUN_MODE 9
`define BIT_STAT_RESET_FN 10

// ****************************************
// Reset values
// ****************************************
`define RST_RESET_PIN_ENABLE 1'h0
`define RST_DEBUG_PIN_ENABLE 1'h1
`define RST_PORT6 6'h00

// ****************************************
// Pin numbers and timing
// ****************************************
`define PIN_RESET 2
`define PIN_DEBUG 3
`define NUM_PINS 6
`define DEBUG_BIT_CYCLES 16
`define BIT_CNT_LAST 4'hF

`endif

// ---- src/pin_mux_pkg.sv ----
// Types shared by the pin mux design
package pin_mux_pkg;

  typedef struct packed {
    logic [5:0] out;
    logic [5:0] oe_n;
    logic [5:0] pull_up;
    logic [5:0] pull_dn;
  } pad_ctrl_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic reset_pin_enable;
    logic debug_pin_enable;
    logic [5:0] port_data;
    logic [5:0] port_dir;
    logic [5:0] pull_en;
    logic [5:0] pull_up_sel;
    logic [5:0] key_en;
    logic cmp_in_en;
    logic cmp_out_en;
    logic timer_ext_clock_in_en;
    logic boot_done;
    logic bg_mode;
    logic drv_prev;
    logic speedup;
    logic line_prev;
    logic [3:0] bit_cnt;
    logic bit_tick;
  } mux_state_t;

endpackage : pin_mux_pkg

// ---- src/shared_pin_function_select.sv ----
// Shared pin function select with reset-time mode sampling
`timescale 1ns/10ps
`include "pin_mux_params.svh"

module shared_pin_function_select
  import pin_mux_pkg::*;
(
  // Clock and power-on reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Avalon-MM slave
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Pads
  input wire logic [5:0] pad_in_i,
  output pad_ctrl_t pad_ctrl_o,
  input wire logic vpp_present_i,
  // Debug controller side
  input wire logic debug_drive_low_i,
  output logic debug_serial_line_o,
  output logic debug_bit_tick_o,
  output logic debug_clk_en_o,
  // Peripheral side
  input wire logic comparator_output_i,
  input wire logic low_power_i,
  output logic [1:0] comparator_in_sel_o,
  output logic timer_ext_clock_in_o,
  output logic key_wake_o,
  // System
  output logic ext_reset_req_o,
  output logic background_mode_o,
  output logic run_mode_o
);

  mux_state_t st;
  mux_state_t next_st;
  pad_ctrl_t pads;
  logic req;
  logic reset_fn;
  logic debug_role;
  logic cmp_owns_pin3;
  logic [5:0] gp_out;
  logic [5:0] gp_oe_n;
  logic [5:0] gp_pull_up;
  logic [5:0] gp_pull_dn;

  // ****************************************
  // Mode decode
  // ****************************************
  function automatic logic run_mode_of(input mux_state_t s);
    return s.boot_done & ~s.bg_mode;
  endfunction : run_mode_of

  // ****************************************
  // Key wake pin mask
  // ****************************************
  // Pin 3 never wakes; reset and comparator functions outrank key wake
  function automatic logic [5:0] key_mask_of(input logic rst_fn, input logic cmp_in);
    logic [5:0] m;
    m = 6'h3F;
    m[`PIN_DEBUG] = 1'h0;
    m[`PIN_RESET] = ~rst_fn;
    m[1:0] = ~{2{cmp_in}};
    return m;
  endfunction : key_mask_of

  // ****************************************
  // Read data decode
  // ****************************************
  function automatic logic [31:0] read_word(input mux_state_t s, input logic [4:0] a,
                                           input logic [5:0] pin);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (a)
      `OFS_SYS_OPTIONS:
      begin
        w[`BIT_RESET_PIN_ENABLE] = s.reset_pin_enable;
        w[`BIT_DEBUG_PIN_ENABLE] = s.debug_pin_enable;
      end
      `OFS_PORT_DATA:
      begin
        w[5:0] = s.port_data;
      end
      `OFS_PORT_DIR:
      begin
        w[5:0] = s.port_dir;
      end
      `OFS_PULL_EN:
      begin
        w[5:0] = s.pull_en;
      end
      `OFS_PULL_UP_SEL:
      begin
        w[5:0] = s.pull_up_sel;
      end
      `OFS_KEY_WAKE_EN:
      begin
        w[5:0] = s.key_en;
      end
      `OFS_PERIPH_CTRL:
      begin
        w[`BIT_CMP_IN_EN] = s.cmp_in_en;
        w[`BIT_CMP_OUT_EN] = s.cmp_out_en;
        w[`BIT_TIMER_EXT_CLOCK_IN_EN] = s.timer_ext_clock_in_en;
      end
      `OFS_PIN_STATUS:
      begin
        w[5:0] = pin;
        w[`PIN_DEBUG] = 1'h0;
        w[`BIT_STAT_BG_MODE] = s.bg_mode;
        w[`BIT_STAT_RUN_MODE] = run_mode_of(s);
        w[`BIT_STAT_RESET_FN] = s.reset_pin_enable;
      end
      default:
      begin
        w = 32'h0000_0000;
      end
    endcase
    return w;
  endfunction : read_word

  // ****************************************
  // Bus request and pin roles
  // ****************************************
  assign req = avs_read_i | avs_write_i;
  assign reset_fn = st.reset_pin_enable;
  // Mode select during reset, debug line afterwards, unless released
  assign debug_role = rst_i | st.debug_pin_enable;
  assign cmp_owns_pin3 = ~debug_role & st.cmp_out_en;

  // ****************************************
  // General pin defaults
  // ****************************************
  for (genvar g = 0; g < `NUM_PINS; g++)
  begin : g_gen_pin
    assign gp_out[g] = st.port_data[g];
    assign gp_oe_n[g] = rst_i | ~st.port_dir[g];
    assign gp_pull_up[g] = ~rst_i & st.pull_en[g] & st.pull_up_sel[g];
    assign gp_pull_dn[g] = ~rst_i & st.pull_en[g] & ~st.pull_up_sel[g];
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    next_st = st;
    next_st.bit_tick = 1'h0;
    next_st.ack = req & ~st.ack;
    if (req & ~st.ack)
    begin
      next_st.rdata = avs_read_i ? read_word(st, avs_address_i, pad_in_i) : 32'h0000_0000;
    end
    // ****************************************
    // Register writes
    // ****************************************
    if (avs_write_i & st.ack)
    begin
      unique case (avs_address_i)
        `OFS_SYS_OPTIONS:
        begin
          // Set only; clearing waits for power-on reset
          if (avs_writedata_i[`BIT_RESET_PIN_ENABLE])
          begin
            next_st.reset_pin_enable = 1'h1;
          end
          next_st.debug_pin_enable = avs_writedata_i[`BIT_DEBUG_PIN_ENABLE];
        end
        `OFS_PORT_DATA:
        begin
          next_st.port_data = avs_writedata_i[5:0];
        end
        `OFS_PORT_DIR:
        begin
          next_st.port_dir = avs_writedata_i[5:0];
        end
        `OFS_PULL_EN:
        begin
          next_st.pull_en = avs_writedata_i[5:0];
        end
        `OFS_PULL_UP_SEL:
        begin
          next_st.pull_up_sel = avs_writedata_i[5:0];
        end
        `OFS_KEY_WAKE_EN:
        begin
          next_st.key_en = avs_writedata_i[5:0];
        end
        `OFS_PERIPH_CTRL:
        begin
          next_st.cmp_in_en = avs_writedata_i[`BIT_CMP_IN_EN];
          next_st.cmp_out_en = avs_writedata_i[`BIT_CMP_OUT_EN];
          next_st.timer_ext_clock_in_en = avs_writedata_i[`BIT_TIMER_EXT_CLOCK_IN_EN];
        end
        default:
        begin
        end
      endcase
    end
    // ****************************************
    // Mode capture
    // ****************************************
    // Mode captured on the first edge after power-on reset release
    if (!st.boot_done)
    begin
      next_st.boot_done = 1'h1;
      next_st.bg_mode = ~pad_in_i[`PIN_DEBUG];
    end
    // ****************************************
    // Debug line timing
    // ****************************************
    // One driven-high cycle after each low pulse ends
    next_st.drv_prev = debug_drive_low_i;
    next_st.speedup = st.drv_prev & ~debug_drive_low_i;
    // Bit timer restarts on each falling edge of the debug line
    next_st.line_prev = pad_in_i[`PIN_DEBUG];
    if (st.line_prev & ~pad_in_i[`PIN_DEBUG])
    begin
      next_st.bit_cnt = 4'h0;
    end
    else if (st.bit_cnt != `BIT_CNT_LAST)
    begin
      next_st.bit_cnt = st.bit_cnt + 4'h1;
      next_st.bit_tick = (st.bit_cnt == 4'(`DEBUG_BIT_CYCLES - 2));
    end
    // ****************************************
    // Power-on reset
    // ****************************************
    if (rst_i)
    begin
      next_st = '0;
      next_st.debug_pin_enable = `RST_DEBUG_PIN_ENABLE;
      next_st.reset_pin_enable = `RST_RESET_PIN_ENABLE;
      next_st.port_dir = `RST_PORT6;
      next_st.pull_en = `RST_PORT6;
      next_st.line_prev = 1'h1;
      next_st.bit_cnt = `BIT_CNT_LAST;
    end
  end

  always_ff @(posedge clk_i)
  begin
    st <= next_st;
  end

  // ****************************************
  // Pad ownership
  // ****************************************
  always_comb
  begin
    pads = '0;
    pads.out = gp_out;
    pads.oe_n = gp_oe_n;
    pads.pull_up = gp_pull_up;
    pads.pull_dn = gp_pull_dn;
    // ****************************************
    // Comparator inputs
    // ****************************************
    // Comparator inputs outrank port use on pins 0 and 1
    if (st.cmp_in_en)
    begin
      pads.oe_n[1:0] = 2'h3;
      pads.pull_up[1:0] = 2'h0;
      pads.pull_dn[1:0] = 2'h0;
    end
    // ****************************************
    // Reset-capable pin
    // ****************************************
    // Pin 2 never drives
    pads.oe_n[`PIN_RESET] = 1'h1;
    pads.out[`PIN_RESET] = 1'h0;
    if (reset_fn)
    begin
      pads.pull_up[`PIN_RESET] = 1'h1;
      pads.pull_dn[`PIN_RESET] = 1'h0;
    end
    if (vpp_present_i)
    begin
      pads.pull_up[`PIN_RESET] = 1'h0;
      pads.pull_dn[`PIN_RESET] = 1'h0;
    end
    // ****************************************
    // Debug and mode pin
    // ****************************************
    // Pin 3 priority: mode select, debug, comparator output, port
    pads.pull_dn[`PIN_DEBUG] = 1'h0;
    if (debug_role)
    begin
      pads.pull_up[`PIN_DEBUG] = 1'h1;
      pads.out[`PIN_DEBUG] = st.speedup;
      pads.oe_n[`PIN_DEBUG] = rst_i | ~(debug_drive_low_i | st.speedup);
    end
    else if (cmp_owns_pin3)
    begin
      pads.pull_up[`PIN_DEBUG] = 1'h0;
      pads.out[`PIN_DEBUG] = comparator_output_i;
      pads.oe_n[`PIN_DEBUG] = 1'h0;
    end
    else
    begin
      pads.pull_up[`PIN_DEBUG] = 1'h0;
      pads.out[`PIN_DEBUG] = st.port_data[`PIN_DEBUG];
      pads.oe_n[`PIN_DEBUG] = 1'h0;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign pad_ctrl_o = pads;
  // ****************************************
  // Bus outputs
  // ****************************************
  assign avs_waitrequest_o = req & ~st.ack;
  assign avs_readdata_o = st.rdata;
  // ****************************************
  // Reset request, mode and debug outputs
  // ****************************************
  assign ext_reset_req_o = reset_fn & ~pad_in_i[`PIN_RESET] & ~rst_i;
  assign background_mode_o = st.bg_mode;
  assign run_mode_o = run_mode_of(st);
  assign debug_serial_line_o = debug_role & pad_in_i[`PIN_DEBUG];
  assign debug_bit_tick_o = st.bit_tick;
  assign debug_clk_en_o = 1'h1;
  // ****************************************
  // Peripheral outputs
  // ****************************************
  assign comparator_in_sel_o = {2{st.cmp_in_en}};
  assign timer_ext_clock_in_o = st.timer_ext_clock_in_en & ~reset_fn & pad_in_i[`PIN_RESET];
  // Key inputs only act as wakeups in stop or wait
  assign key_wake_o = low_power_i & |(st.key_en & ~pad_in_i
                      & key_mask_of(reset_fn, st.cmp_in_en));

endmodule : shared_pin_function_select

// ---- testbench/pad_board_model.sv ----
// Board model: debug host, reset source, pulls and pad wire levels
`timescale 1ns/10ps
module pad_board_model
  import pin_mux_pkg::*;
(
  // Clock and drivers
  input wire logic clk_i,
  input wire pad_ctrl_t pad_ctrl_i,
  input wire logic [5:0] hold_low_i,
  // Wire levels
  output logic [5:0] pad_in_o
);
  logic wobble = 1'b0;
  // A floating pad changes every cycle so no stale level is seen
  always @(posedge clk_i) wobble <= ~wobble;
  always_comb
  begin
    for (int i = 0; i < 6; i++)
      pad_in_o[i] = !pad_ctrl_i.oe_n[i] ? pad_ctrl_i.out[i] : hold_low_i[i] ? 1'b0 :
        pad_ctrl_i.pull_up[i] ? 1'b1 : pad_ctrl_i.pull_dn[i] ? 1'b0 : wobble ^ i[0];
  end
endmodule : pad_board_model

// ---- testbench/pin_mux_chk.sv ----
// Port assertions for the shared pin function select
`timescale 1ns/10ps
module pin_mux_chk
  import pin_mux_pkg::*;
(
  // Watched ports
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [5:0] pad_in_i,
  input wire logic vpp_present_i,
  input wire logic debug_drive_low_i,
  input wire logic low_power_i,
  input wire pad_ctrl_t pad_ctrl_o,
  input wire logic debug_serial_line_o,
  input wire logic debug_bit_tick_o,
  input wire logic debug_clk_en_o,
  input wire logic key_wake_o,
  input wire logic ext_reset_req_o,
  input wire logic background_mode_o,
  input wire logic run_mode_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_fall;
    $fell(debug_serial_line_o) && pad_ctrl_o.oe_n[3] && $past(pad_ctrl_o.oe_n[3]) && !$past(rst_i);
  endsequence
  sequence s_tick16;
    ##16 debug_bit_tick_o;
  endsequence
  property p_boot;
    $fell(rst_i) |-> {pad_ctrl_o.oe_n, pad_ctrl_o.pull_up, pad_ctrl_o.pull_dn} == 18'h3F200;
  endproperty
  property p_mode;
    $fell(rst_i) |=> run_mode_o == $past(pad_in_i[3]) && background_mode_o == !$past(pad_in_i[3]);
  endproperty
  property p_tick;
    s_fall |-> s_tick16;
  endproperty
  property p_speed;
    $fell(debug_drive_low_i) && $past(!pad_ctrl_o.oe_n[3] && !pad_ctrl_o.out[3])
      |-> ##[0:1] (pad_ctrl_o.out[3] && !pad_ctrl_o.oe_n[3]);
  endproperty
  property p_vpp;
    vpp_present_i |-> !pad_ctrl_o.pull_up[2] && !pad_ctrl_o.pull_dn[2];
  endproperty
  property p_rreq;
    ext_reset_req_o |-> !pad_in_i[2] && (vpp_present_i || pad_ctrl_o.pull_up[2]);
  endproperty
  property p_key;
    key_wake_o |-> low_power_i;
  endproperty
  property p_clk;
    debug_clk_en_o;
  endproperty
  a_boot: assert property (p_boot) else $error("pads not idle after reset");
  a_mode: assert property (p_mode) else $error("mode not taken from pin3");
  a_tick: assert property (p_tick) else $error("bit tick not 16 cycles");
  a_speed: assert property (p_speed) else $error("no speedup pulse");
  a_vpp: assert property (p_vpp) else $error("pin2 pull on with vpp");
  a_rreq: assert property (p_rreq) else $error("bad reset request");
  a_key: assert property (p_key) else $error("key wake in run");
  a_clk: assert property (p_clk) else $error("debug clock off");
endmodule : pin_mux_chk

bind shared_pin_function_select pin_mux_chk i_chk (
  .clk_i, .rst_i, .pad_in_i, .vpp_present_i, .debug_drive_low_i, .low_power_i, .pad_ctrl_o,
  .debug_serial_line_o, .debug_bit_tick_o, .debug_clk_en_o, .key_wake_o, .ext_reset_req_o,
  .background_mode_o, .run_mode_o
);

// ---- testbench/shared_pin_function_select_tb_top.sv ----
// Self-checking bench for the shared pin function select
`timescale 1ns/10ps
`include "pin_mux_params.svh"
module shared_pin_function_select_tb_top
  import pin_mux_pkg::*;
;
  logic clk_i, rst_i, avs_read_i, avs_write_i, vpp_present_i, debug_drive_low_i, seen;
  logic comparator_output_i, low_power_i, avs_waitrequest_o, debug_serial_line_o;
  logic debug_bit_tick_o, debug_clk_en_o, timer_ext_clock_in_o, key_wake_o;
  logic ext_reset_req_o, background_mode_o, run_mode_o;
  logic [1:0] comparator_in_sel_o;
  logic [4:0] avs_address_i;
  logic [5:0] pad_in_i, hold_low;
  logic [31:0] avs_writedata_i, avs_readdata_o, rd;
  pad_ctrl_t pad_ctrl_o;
  int fail_count = 0, samples_checked = 0, cycles = 0;
  shared_pin_function_select i_dut (
    .clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_readdata_o, .avs_waitrequest_o, .pad_in_i, .pad_ctrl_o, .vpp_present_i,
    .debug_drive_low_i, .debug_serial_line_o, .debug_bit_tick_o, .debug_clk_en_o,
    .comparator_output_i, .low_power_i, .comparator_in_sel_o, .timer_ext_clock_in_o,
    .key_wake_o, .ext_reset_req_o, .background_mode_o, .run_mode_o
  );
  pad_board_model i_board (
    .clk_i, .pad_ctrl_i(pad_ctrl_o), .hold_low_i(hold_low), .pad_in_o(pad_in_i)
  );
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Holds the request until waitrequest is sampled low
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {avs_address_i, avs_writedata_i, avs_write_i, avs_read_i} <= {a, d, wr, !wr};
    #1;
    while (avs_waitrequest_o !== 1'b0)
    begin
      @(posedge clk_i);
      #1;
    end
    @(posedge clk_i);
    rd = avs_readdata_o;
    {avs_write_i, avs_read_i} <= 2'b00;
  endtask : bus
  task settle;
    repeat (2) @(posedge clk_i);
    #1;
  endtask : settle
  task complete_run;
    $display("checks %0d failures %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  task do_reset(input logic host_low);
    {rst_i, hold_low[3]} <= {1'b1, host_low};
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    hold_low[3] <= 1'b0;
    #1;
    chk("run", !host_low, run_mode_o);
    chk("bg", host_low, background_mode_o);
    chk("pads", 18'h3F200, {pad_ctrl_o.oe_n, pad_ctrl_o.pull_up, pad_ctrl_o.pull_dn});
    bus(1'b0, `OFS_SYS_OPTIONS, 32'h0);
    chk("options", 32'h2, rd);
    bus(1'b0, `OFS_PIN_STATUS, 32'h0);
    chk("status", host_low ? 32'h100 : 32'h200, rd & 32'h700);
    $display("test reset done");
  endtask : do_reset
  task t_reset_pin;
    bus(1'b1, `OFS_SYS_OPTIONS, 32'h3);
    settle();
    chk("pin2 pull", 1'b1, pad_ctrl_o.pull_up[2]);
    @(posedge clk_i) hold_low[2] <= 1'b1;
    settle();
    chk("reset req", 1'b1, ext_reset_req_o);
    @(posedge clk_i) hold_low[2] <= 1'b0;
    bus(1'b1, `OFS_SYS_OPTIONS, 32'h2);
    bus(1'b0, `OFS_PIN_STATUS, 32'h0);
    chk("reset fn", 32'h400, rd & 32'h400);
    @(posedge clk_i) vpp_present_i <= 1'b1;
    settle();
    chk("vpp pulls", 2'b00, {pad_ctrl_o.pull_up[2], pad_ctrl_o.pull_dn[2]});
    @(posedge clk_i) vpp_present_i <= 1'b0;
    $display("test reset pin done");
  endtask : t_reset_pin
  task t_debug;
    chk("pin3 pull", 1'b1, pad_ctrl_o.pull_up[3]);
    @(posedge clk_i) hold_low[3] <= 1'b1;
    seen = 1'b0;
    repeat (20)
    begin
      @(posedge clk_i);
      seen |= debug_bit_tick_o;
    end
    chk("tick", 1'b1, seen);
    chk("line", 1'b0, debug_serial_line_o);
    hold_low[3] <= 1'b0;
    @(posedge clk_i) debug_drive_low_i <= 1'b1;
    settle();
    chk("drive low", 2'b00, {pad_ctrl_o.out[3], pad_ctrl_o.oe_n[3]});
    @(posedge clk_i) debug_drive_low_i <= 1'b0;
    seen = 1'b0;
    repeat (3)
    begin
      #1 seen |= pad_ctrl_o.out[3] & ~pad_ctrl_o.oe_n[3];
      @(posedge clk_i);
    end
    chk("speedup", 1'b1, seen);
    $display("test debug done");
  endtask : t_debug
  task t_port;
    bus(1'b1, `OFS_SYS_OPTIONS, 32'h1);
    bus(1'b1, `OFS_PORT_DATA, 32'h8);
    settle();
    chk("pin3 port", 2'b10, {pad_ctrl_o.out[3], pad_ctrl_o.oe_n[3]});
    bus(1'b0, `OFS_PIN_STATUS, 32'h0);
    chk("pin3 in", 32'h0, rd & 32'h8);
    bus(1'b1, `OFS_PERIPH_CTRL, 32'h3);
    bus(1'b1, `OFS_PULL_EN, 32'h30);
    bus(1'b1, `OFS_PULL_UP_SEL, 32'h10);
    bus(1'b1, `OFS_KEY_WAKE_EN, 32'h13);
    @(posedge clk_i) low_power_i <= 1'b1;
    settle();
    chk("cmp out", 1'b0, pad_ctrl_o.out[3]);
    chk("cmp in", 2'b11, comparator_in_sel_o);
    chk("pulls", 4'b0110, {pad_ctrl_o.pull_up[5:4], pad_ctrl_o.pull_dn[5:4]});
    chk("key cmp", 1'b0, key_wake_o);
    @(posedge clk_i) hold_low[4] <= 1'b1;
    settle();
    chk("key wake", 1'b1, key_wake_o);
    bus(1'b0, 5'h02, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("test port done");
  endtask : t_port
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      complete_run();
    end
  end
  initial
  begin
    {rst_i, avs_read_i, avs_write_i, vpp_present_i, debug_drive_low_i} = 5'h10;
    {comparator_output_i, low_power_i, avs_address_i, hold_low} = 13'h0;
    avs_writedata_i = 32'h0;
    do_reset(1'b0);
    t_reset_pin();
    t_debug();
    t_port();
    do_reset(1'b1);
    complete_run();
  end
endmodule : shared_pin_function_select_tb_top
